// ---- fce_encoder.sv ----
/*
 * Fault code encoder. Builds the sixteen-bit fault code and captures the
 * whole fault record in one cycle when a fault event other than a binding lock failure is presented while idle, and
 * exposes the record over APB.
 * Assumes the execution units present one fault event per pulse, with all
 * event fields valid in that cycle, and that all inputs are synchronous to pclk.
 */
// What this block does
// - Class 11 for type tests and cache qualification faults, 00 for other and the remaining fixed faults
// - Class 10 for memory access faults
// - Copy status and timer registers into record
// - Operator id zero during instruction decode
// - Nonzero execution state only for port/IPC
// - Access target bits: memory, interconnect, segment
// - Five independent access fault kind bits
// - Read-modify-write flag set for indivisible access
// - Direction flag zero read, one write
// - Displacement or selector index holds fault offset
// - Four-bit segment selector code stored
// - Top bit: zero system, one entry test
// - Qualification flag picks directory or object index
// - Expected system type code 00000 to 01100
// - Expected entry attribute bits stored
// - Processor class 00, 01 or 10
// - Level and four-bit fault kind low bits
// - Sixteen fault kinds per level
// - Invalid opcode and processor stopped codes
// - Cache qualification failures coded as type tests
// - Access descriptor store level and delete faults
// - Port operation lock and queue faults
// - Processor binding faults, lock failure fatal when idle
module fce_encoder
   import fce_pkg::*;
#(
   parameter int OPID_W = 8,
   parameter int XST_W  = 4,
   parameter int REG_W  = 16
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              fault_valid,
   input  wire logic [3:0]        fault_src,
   input  wire logic              in_decode,
   input  wire logic [OPID_W-1:0] operator_id,
   input  wire logic              port_or_ipc,
   input  wire logic [XST_W-1:0]  exec_state,
   input  wire logic [1:0]        access_target_kind,
   input  wire logic [4:0]        access_fault_kinds,
   input  wire logic              rmw_access,
   input  wire logic              write_access,
   input  wire logic [3:0]        segment_selector_code,
   input  wire logic [REG_W-1:0]  fault_offset,
   input  wire logic              entry_test,
   input  wire logic              ot_qualification,
   input  wire logic [REG_W-1:0]  directory_index,
   input  wire logic [REG_W-1:0]  object_indices,
   input  wire logic [4:0]        expected_type_code,
   input  wire logic [4:0]        entry_attribute_bits,
   input  wire logic [1:0]        processor_class,
   input  wire logic [1:0]        fault_level,
   input  wire logic [3:0]        fault_kind,
   input  wire logic [1:0]        port_fault_sel,
   input  wire logic              bind_lock_fail,
   input  wire logic              bind_carrier_fail,
   input  wire logic [REG_W-1:0]  subsys_status,
   input  wire logic [REG_W-1:0]  ctx_status,
   input  wire logic [REG_W-1:0]  proc_status,
   input  wire logic [31:0]       system_timer,
   output logic                   record_valid,
   output logic [15:0]            fault_code,
   output logic                   fatal_fault
);

   typedef enum logic [2:0] {
      FCE_ST_IDLE  = 3'b001,
      FCE_ST_HELD  = 3'b010,
      FCE_ST_FATAL = 3'b100
   } fce_state_t;

   // Packs an FF-class code from a six-bit level/kind value.
   function automatic logic [15:0] fce_other(input logic [5:0] lk);
      fce_other = {FCE_CLS_OTHER, 8'h00, lk};
   endfunction : fce_other

   // Packs a TS-class code from its low byte; the low byte repeats bit 7 at the top.
   function automatic logic [15:0] fce_ts(input logic [7:0] lo);
      fce_ts = {lo[7], FCE_CLS_TYPE_TEST, 5'h00, lo};
   endfunction : fce_ts

   fce_state_t          state_q, state_d;
   logic [15:0]         code_q;
   logic [OPID_W-1:0]   opid_q;
   logic [XST_W-1:0]    xst_q;
   logic [REG_W-1:0]    disp_q, sel_q, subsys_q, ctx_q, procst_q;
   logic [31:0]         timer_q;
   logic [15:0]         count_q;
   logic                ctrl_hold_q;
   logic [31:0]         prdata_q;
   logic                pready_q, pslverr_q;

   wire logic [15:0] mem_code;
   wire logic [15:0] ts_code;
   wire logic [15:0] oth_code;
   wire logic [15:0] port_code;
   wire logic [15:0] code_next;
   wire logic [5:0]  port_lk;
   wire logic        accept;
   wire logic        setup;
   wire logic        wr_ctrl;
   wire logic        bad_ts;
   wire logic [4:0]  ts_low;

   assign mem_code = {1'b0, FCE_CLS_MEM_ACC, access_fault_kinds, access_target_kind,
                      rmw_access, write_access, segment_selector_code};
   assign ts_low = entry_test ? entry_attribute_bits : expected_type_code;
   assign ts_code = {entry_test, FCE_CLS_TYPE_TEST, 5'h00, ot_qualification,
                     entry_test ? 2'h0 : processor_class, ts_low};
   // Out-of-range expected types are still recorded; bad_ts is visible in status.
   assign bad_ts = !entry_test && ((expected_type_code > FCE_SYS_TYPE_MAX)
                   || (processor_class > FCE_PCLS_MAX));
   assign oth_code = fce_other({fault_level, fault_kind});
   assign port_lk = (port_fault_sel == 2'h0) ? FCE_F_CARRIER_LOCK :
                    (port_fault_sel == 2'h1) ? FCE_F_WAKEUP_IPC :
                    (port_fault_sel == 2'h2) ? FCE_F_PORT_LOCK : FCE_F_CARRIER_QD;
   assign port_code = fce_other(port_lk);

   assign code_next =
      (fault_src == FCE_SRC_MEM)     ? mem_code :
      (fault_src == FCE_SRC_TYPE)    ? ts_code :
      (fault_src == FCE_SRC_OTHER)   ? oth_code :
      (fault_src == FCE_SRC_INV_OP)  ? fce_other(FCE_F_INVALID_OP) :
      (fault_src == FCE_SRC_STOP)    ? fce_other(FCE_F_PROC_STOP) :
      (fault_src == FCE_SRC_OTC_ENT) ? fce_ts(FCE_TS_OTC_ENTRY) :
      (fault_src == FCE_SRC_OTC_SYS) ? fce_ts(FCE_TS_OTC_SYSTYPE) :
      (fault_src == FCE_SRC_AD_LVL)  ? fce_other(FCE_F_AD_LEVEL) :
      (fault_src == FCE_SRC_AD_DEL)  ? fce_other(FCE_F_DEL_RIGHTS) :
      (fault_src == FCE_SRC_PORT)    ? port_code :
      (bind_carrier_fail ? fce_other(FCE_F_PCARR_LOCK)
                         : fce_other(FCE_F_MASK_BASE));

   // A held record is not overwritten until software releases it, so the
   // first fault of a burst survives; later ones are only counted.
   assign accept  = fault_valid && (fault_src != FCE_SRC_NONE) && (fault_src < FCE_SRC_CNT)
                    && (state_q == FCE_ST_IDLE);
   assign setup   = psel && !penable;
   assign wr_ctrl = psel && penable && pwrite && (paddr == FCE_A_CTRL);

   always_comb begin
      state_d = state_q;
      case (state_q)
         FCE_ST_IDLE: begin
            if (fault_valid && fault_src == FCE_SRC_BIND && bind_lock_fail) begin
               state_d = FCE_ST_FATAL;
            end else if (accept) begin
               state_d = FCE_ST_HELD;
            end
         end
         FCE_ST_HELD: begin
            if (wr_ctrl && pwdata[0]) begin
               state_d = FCE_ST_IDLE;
            end
         end
         FCE_ST_FATAL: state_d = FCE_ST_FATAL;
         default: state_d = FCE_ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= FCE_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Record capture: every field in the same edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_q   <= 16'h0000;
         opid_q   <= '0;
         xst_q    <= '0;
         disp_q   <= '0;
         sel_q    <= '0;
         subsys_q <= '0;
         ctx_q    <= '0;
         procst_q <= '0;
         timer_q  <= 32'h0000_0000;
      end else if (accept && !(fault_src == FCE_SRC_BIND && bind_lock_fail)) begin
         code_q   <= code_next;
         opid_q   <= in_decode ? '0 : operator_id;
         xst_q    <= port_or_ipc ? exec_state : '0;
         disp_q   <= (fault_src == FCE_SRC_MEM && access_target_kind != FCE_TGT_ASEG)
                     ? fault_offset : '0;
         sel_q    <= (fault_src == FCE_SRC_MEM && access_target_kind == FCE_TGT_ASEG) ? fault_offset :
                     (fault_src == FCE_SRC_TYPE) ?
                        (ot_qualification ? directory_index : object_indices) : '0;
         subsys_q <= subsys_status;
         ctx_q    <= ctx_status;
         procst_q <= proc_status;
         timer_q  <= system_timer;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q     <= 16'h0000;
         ctrl_hold_q <= 1'b0;
      end else begin
         if (fault_valid && fault_src != FCE_SRC_NONE) begin
            count_q <= count_q + 16'h0001;
         end
         if (wr_ctrl) begin
            ctrl_hold_q <= pwdata[1];
         end
      end
   end

   // APB slave: zero wait states, every access answered in its access phase.
   wire logic [31:0] rd_mux;
   wire logic        addr_ok;
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= FCE_A_COUNT);
   assign rd_mux =
      (paddr == FCE_A_CTRL)   ? {30'h0, ctrl_hold_q, 1'b0} :
      (paddr == FCE_A_STATUS) ? {28'h0, bad_ts, state_q} :
      (paddr == FCE_A_CODE)   ? {16'h0, code_q} :
      (paddr == FCE_A_OPID)   ? 32'({xst_q, opid_q}) :
      (paddr == FCE_A_DISP)   ? 32'(disp_q) :
      (paddr == FCE_A_SEL)    ? 32'(sel_q) :
      (paddr == FCE_A_SUBSYS) ? 32'(subsys_q) :
      (paddr == FCE_A_CTXST)  ? 32'(ctx_q) :
      (paddr == FCE_A_PROCST) ? 32'(procst_q) :
      (paddr == FCE_A_TIMER)  ? timer_q :
      (paddr == FCE_A_COUNT)  ? {16'h0, count_q} : FCE_BAD_ADDR_DATA;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !addr_ok;
         prdata_q  <= (setup && !pwrite && addr_ok) ? rd_mux : 32'h0000_0000;
      end
   end

   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign record_valid = (state_q == FCE_ST_HELD);
   assign fault_code   = code_q;
   assign fatal_fault  = (state_q == FCE_ST_FATAL);

endmodule : fce_encoder

// ---- fce_pkg.sv ----
/*
 * Constants for the fault code encoder: fault classes, field positions,
 * fixed fault codes and the APB register map.
 * Assumes a 32-bit APB bus and a single pclk domain.
 */
package fce_pkg;
   localparam logic [1:0] FCE_CLS_TYPE_TEST = 2'h3;
   localparam logic [1:0] FCE_CLS_MEM_ACC   = 2'h2;
   localparam logic [1:0] FCE_CLS_OTHER     = 2'h0;
   localparam int FCE_CLS_LSB     = 13;
   localparam int FCE_TOP_BIT     = 15;
   localparam int FCE_KIND5_LSB   = 8;
   localparam int FCE_TGT_LSB     = 6;
   localparam int FCE_RMW_BIT     = 5;
   localparam int FCE_DIR_BIT     = 4;
   localparam int FCE_QUAL_BIT    = 7;
   localparam int FCE_PCLS_LSB    = 5;
   localparam int FCE_LEVEL_LSB   = 4;
   localparam logic [1:0] FCE_TGT_MEM  = 2'h0;
   localparam logic [1:0] FCE_TGT_ICON = 2'h2;
   localparam logic [1:0] FCE_TGT_ASEG = 2'h3;
   localparam logic [4:0] FCE_SYS_TYPE_MAX = 5'h0C;
   localparam logic [1:0] FCE_PCLS_MAX     = 2'h2;
   localparam logic [5:0] FCE_F_INVALID_OP   = 6'h0C;
   localparam logic [5:0] FCE_F_PROC_STOP    = 6'h3D;
   localparam logic [5:0] FCE_F_AD_LEVEL     = 6'h14;
   localparam logic [5:0] FCE_F_DEL_RIGHTS   = 6'h13;
   localparam logic [5:0] FCE_F_CARRIER_LOCK = 6'h19;
   localparam logic [5:0] FCE_F_WAKEUP_IPC   = 6'h34;
   localparam logic [5:0] FCE_F_PORT_LOCK    = 6'h1A;
   localparam logic [5:0] FCE_F_CARRIER_QD   = 6'h36;
   localparam logic [5:0] FCE_F_MASK_BASE    = 6'h38;
   localparam logic [5:0] FCE_F_PCARR_LOCK   = 6'h30;
   localparam logic [7:0] FCE_TS_OTC_ENTRY   = 8'h97;
   localparam logic [7:0] FCE_TS_OTC_SYSTYPE = 8'h82;
   localparam logic [3:0] FCE_SRC_CNT = 4'hC;
   localparam logic [3:0] FCE_SRC_NONE     = 4'h0;
   localparam logic [3:0] FCE_SRC_MEM      = 4'h1;
   localparam logic [3:0] FCE_SRC_TYPE     = 4'h2;
   localparam logic [3:0] FCE_SRC_OTHER    = 4'h3;
   localparam logic [3:0] FCE_SRC_INV_OP   = 4'h4;
   localparam logic [3:0] FCE_SRC_STOP     = 4'h5;
   localparam logic [3:0] FCE_SRC_OTC_ENT  = 4'h6;
   localparam logic [3:0] FCE_SRC_OTC_SYS  = 4'h7;
   localparam logic [3:0] FCE_SRC_AD_LVL   = 4'h8;
   localparam logic [3:0] FCE_SRC_AD_DEL   = 4'h9;
   localparam logic [3:0] FCE_SRC_PORT     = 4'hA;
   localparam logic [3:0] FCE_SRC_BIND     = 4'hB;
   localparam logic [11:0] FCE_A_CTRL   = 12'h000;
   localparam logic [11:0] FCE_A_STATUS = 12'h004;
   localparam logic [11:0] FCE_A_CODE   = 12'h008;
   localparam logic [11:0] FCE_A_OPID   = 12'h00C;
   localparam logic [11:0] FCE_A_DISP   = 12'h010;
   localparam logic [11:0] FCE_A_SEL    = 12'h014;
   localparam logic [11:0] FCE_A_SUBSYS = 12'h018;
   localparam logic [11:0] FCE_A_CTXST  = 12'h01C;
   localparam logic [11:0] FCE_A_PROCST = 12'h020;
   localparam logic [11:0] FCE_A_TIMER  = 12'h024;
   localparam logic [11:0] FCE_A_COUNT  = 12'h028;
   localparam logic [31:0] FCE_BAD_ADDR_DATA = 32'h0000_0000;
endpackage : fce_pkg

// ---- fce_exec_model.sv ----
/* Processor-side status source for the fault code encoder bench.
   Assumes one pclk domain with the active-low asynchronous presetn. */
module fce_exec_model (
   input  wire logic   pclk,
   input  wire logic   presetn,
   output logic [15:0] subsys_status,
   output logic [15:0] ctx_status,
   output logic [15:0] proc_status,
   output logic [31:0] system_timer
);
   timeunit 1ns;
   timeprecision 1ps;
   // Status words move every cycle, so a capture taken one cycle off cannot match by luck.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) {subsys_status, ctx_status, proc_status, system_timer} <= '0;
      else {subsys_status, ctx_status, proc_status, system_timer} <=
         {16'($urandom), 32'($urandom), system_timer + 32'h1};
   end
endmodule : fce_exec_model

// ---- fce_encoder_properties.sv ----
/* Concurrent checks on the fault code encoder ports.
   Assumes one pclk domain and the active-low asynchronous presetn. */
module fce_encoder_properties
   import fce_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        pready,
   input wire logic        fault_valid,
   input wire logic [3:0]  fault_src,
   input wire logic [1:0]  access_target_kind,
   input wire logic [4:0]  access_fault_kinds,
   input wire logic        rmw_access,
   input wire logic        write_access,
   input wire logic [3:0]  segment_selector_code,
   input wire logic        entry_test,
   input wire logic        ot_qualification,
   input wire logic [4:0]  expected_type_code,
   input wire logic [4:0]  entry_attribute_bits,
   input wire logic [1:0]  processor_class,
   input wire logic [1:0]  fault_level,
   input wire logic [3:0]  fault_kind,
   input wire logic        bind_lock_fail,
   input wire logic        bind_carrier_fail,
   input wire logic        record_valid,
   input wire logic [15:0] fault_code,
   input wire logic        fatal_fault
);
   localparam logic [15:0] FIX_TAB [4:9] = '{16'h000C, 16'h003D, 16'hE097, 16'hE082, 16'h0014, 16'h0013};
   // Events are only captured from the idle state, so every check of a newly captured code keys on it.
   wire take = fault_valid && !record_valid && !fatal_fault;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   mem_code_a: assert property (take && fault_src == FCE_SRC_MEM
      |=> fault_code == {3'h2, $past(access_fault_kinds), $past(access_target_kind), $past(rmw_access),
      $past(write_access), $past(segment_selector_code)}) else $error("memory fault code wrong");
   ts_code_a: assert property (take && fault_src == FCE_SRC_TYPE
      |=> fault_code == {$past(entry_test), 7'h60, $past(ot_qualification),
      $past(entry_test) ? 2'h0 : $past(processor_class),
      $past(entry_test) ? $past(entry_attribute_bits) : $past(expected_type_code)})
      else $error("type test code wrong");
   other_code_a: assert property (take && fault_src == FCE_SRC_OTHER
      |=> fault_code == {10'h000, $past(fault_level), $past(fault_kind)}) else $error("level code wrong");
   fixed_code_a: assert property (take && fault_src inside {[FCE_SRC_INV_OP:FCE_SRC_AD_DEL]}
      |=> fault_code == FIX_TAB[$past(fault_src)]) else $error("fixed code wrong");
   bind_code_a: assert property (take && fault_src == FCE_SRC_BIND && !bind_lock_fail
      |=> fault_code == ($past(bind_carrier_fail) ? 16'h0030 : 16'h0038)) else $error("binding code wrong");
   bind_fatal_a: assert property (take && fault_src == FCE_SRC_BIND && bind_lock_fail
      |=> fatal_fault && !record_valid) else $error("lock failure not fatal");
   held_code_a: assert property (record_valid && !pready |=> record_valid && $stable(fault_code))
      else $error("held record changed");
   fatal_hold_a: assert property (fatal_fault |=> fatal_fault && !record_valid)
      else $error("fatal state left");
endmodule : fce_encoder_properties
bind fce_encoder fce_encoder_properties fce_encoder_properties_inst (.*);

// ---- tb.sv ----
/* Self-checking bench for fce_encoder: APB master, fault event driver and a reference model.
   Assumes fce_pkg, fce_encoder and fce_exec_model are compiled first. */
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %0t mismatch", $time); end end
module tb
   import fce_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fault_valid, in_decode, port_or_ipc, err;
   logic        rmw_access, write_access, entry_test, ot_qualification, bind_lock_fail, bind_carrier_fail;
   logic        record_valid, fatal_fault;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, system_timer, rd, snap_tim;
   logic [15:0] fault_offset, directory_index, object_indices, subsys_status, ctx_status, proc_status;
   logic [15:0] fault_code, m_code, snap_sub, snap_ctx, snap_prc;
   logic [7:0]  operator_id;
   logic [4:0]  access_fault_kinds, expected_type_code, entry_attribute_bits;
   logic [3:0]  fault_src, exec_state, segment_selector_code, fault_kind;
   logic [1:0]  access_target_kind, processor_class, fault_level, port_fault_sel;
   logic [5:0]  port_tab [4] = '{6'h19, 6'h34, 6'h1A, 6'h36};
   logic [15:0] fix_tab [4:9] = '{16'h000C, 16'h003D, 16'hE097, 16'hE082, 16'h0014, 16'h0013};
   int          fail_count, check_count, cnt, m_state;
   fce_encoder fce_encoder_inst (.*);
   fce_exec_model fce_exec_model_inst (.*);
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   task automatic close_out(input int hung);
      fail_count += hung;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, wd};
      @(posedge pclk);
      penable <= 1'h1;
      // The answer is taken at the very edge that samples pready high, never before it.
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'h1) break;
      end
      if (n == 20) close_out(1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask : apb
   task automatic readchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      `CHK(rd, e)
   endtask : readchk
   task automatic fill;
      {in_decode, port_or_ipc, rmw_access, write_access, entry_test, ot_qualification, bind_carrier_fail,
         operator_id, exec_state, access_target_kind, access_fault_kinds, segment_selector_code} <= 30'($urandom);
      {fault_offset, directory_index} <= $urandom;
      {object_indices, entry_attribute_bits, fault_level, fault_kind, port_fault_sel} <= 29'($urandom);
      expected_type_code <= 5'($urandom % 32'hD);
      processor_class <= 2'($urandom % 32'h3);
   endtask : fill
   task automatic send(input logic [3:0] s, input logic lk);
      logic [15:0] e;
      @(posedge pclk);
      fill();
      {fault_src, bind_lock_fail, fault_valid} <= {s, lk, 1'h1};
      #1;
      e = (s == 4'h1) ? {3'h2, access_fault_kinds, access_target_kind, rmw_access, write_access, segment_selector_code}
        : (s == 4'h2) ? {entry_test, 7'h60, ot_qualification, entry_test ? 2'h0 : processor_class,
                         entry_test ? entry_attribute_bits : expected_type_code}
        : (s == 4'h3) ? {10'h000, fault_level, fault_kind}
        : (s == 4'hA) ? {10'h000, port_tab[port_fault_sel]}
        : (s == 4'hB) ? (bind_carrier_fail ? 16'h0030 : 16'h0038) : fix_tab[s];
      snap_sub = subsys_status;
      snap_ctx = ctx_status;
      snap_prc = proc_status;
      snap_tim = system_timer;
      cnt++;
      if (m_state == 0) m_code = e;
      if (m_state == 0) m_state = (s == 4'hB && lk) ? 2 : 1;
      @(posedge pclk);
      fault_valid <= 1'h0;
      #1;
      `CHK(record_valid, m_state == 1)
      `CHK(fatal_fault, m_state == 2)
      if (m_state == 1) `CHK(fault_code, m_code)
   endtask : send
   initial begin
      void'($urandom(32'h818C));
      {psel, penable, pwrite, paddr, pwdata, fault_src, fault_valid, bind_lock_fail} = '0;
      presetn = 1'h0;
      fill();
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      readchk(FCE_A_STATUS, 32'h1);
      apb(1'h0, 12'h02C, 32'h0);
      `CHK({err, rd}, 33'h100000000)
      $display("test reset done");
      for (int r = 0; r < 3; r++) begin
         for (int i = 1; i < 12; i++) begin
            send(4'(i), 1'h0);
            readchk(FCE_A_CODE, {16'h0, m_code});
            readchk(FCE_A_OPID, {20'h0, port_or_ipc ? exec_state : 4'h0, in_decode ? 8'h00 : operator_id});
            readchk(FCE_A_SUBSYS, {16'h0, snap_sub});
            readchk(FCE_A_TIMER, snap_tim);
            readchk(FCE_A_CTXST, {16'h0, snap_ctx});
            readchk(FCE_A_PROCST, {16'h0, snap_prc});
            if (i == 1) readchk(access_target_kind == 2'h3 ? FCE_A_SEL : FCE_A_DISP, {16'h0, fault_offset});
            if (i == 2) readchk(FCE_A_SEL, {16'h0, ot_qualification ? directory_index : object_indices});
            send(4'h3, 1'h0);
            apb(1'h1, FCE_A_CTRL, 32'h1);
            m_state = 0;
            #1;
            `CHK(record_valid, 1'h0)
         end
      end
      $display("test encodings done");
      send(4'hB, 1'h1);
      send(4'h4, 1'h0);
      readchk(FCE_A_STATUS, 32'h4);
      readchk(FCE_A_COUNT, cnt);
      $display("test fatal done");
      // Only a reset leaves the fatal state; recording must work again after it.
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      #1;
      `CHK({record_valid, fatal_fault, fault_code}, 18'h0)
      m_state = 0;
      readchk(FCE_A_COUNT, 32'h0);
      apb(1'h1, FCE_A_CTRL, 32'h2);
      readchk(FCE_A_CTRL, 32'h2);
      entry_test <= 1'h0;
      expected_type_code <= 5'h1F;
      readchk(FCE_A_STATUS, 32'h9);
      send(4'h3, 1'h0);
      $display("test second reset done");
      close_out(0);
   end
endmodule : tb
